/* design/otp_pattern_gen.v */
// output test pattern generator and word serializer in front of the output framer
// assumes the bit clock comes from outside and is sampled here; samples arrive on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "otp_defs.vh"

module otp_pattern_gen (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // configuration port
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [11:0] cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata_q,
  // processed samples
  input  wire [15:0] sample_data,
  output reg         sample_take_q,
  // serial link
  input  wire        bit_clk,
  output reg         ser_data_q,
  output reg         word_start_q
);

  // configuration registers
  reg  [3:0]  mode_q;
  reg  [7:0]  user1_lo_q;
  reg  [7:0]  user1_hi_q;
  reg  [7:0]  user2_lo_q;
  reg  [7:0]  user2_hi_q;
  reg  [7:0]  fmt_q;
  reg  [7:0]  stuff_q;
  // link clock sampling
  reg  [2:0]  bclk_sync_q;
  reg         bclk_stable_q;
  wire        bit_edge;
  // serializer state
  reg  [3:0]  act_mode_q;
  reg  [4:0]  bit_cnt_q;
  reg  [15:0] shreg_q;
  reg         tog_q;
  reg         iq_q;
  reg  [3:0]  stuff_left_q;
  reg         pn_on_q;
  reg         zero_word_q;
  // word boundary decisions
  wire        boundary;
  wire        stuffing;
  wire        new_pn;
  wire        pn_restart;
  wire [4:0]  wl_bits;
  wire [15:0] word;
  wire [15:0] word_al;
  wire        lsb_first;
  wire        pns_bit;
  wire        pnl_bit;
  wire        pn_bit;
  wire        pn_step;
  wire        tog_sel;

  // a mode change restarts two-word patterns at word one
  assign tog_sel = (mode_q == act_mode_q) ? tog_q : 1'b0;

  // length in bits of the selected output word
  function [4:0] wl_of;
    input [1:0] code;
    begin
      case (code)
        `OTP_WL_16: wl_of = `OTP_BITS_16;
        `OTP_WL_12: wl_of = `OTP_BITS_12;
        default:    wl_of = `OTP_BITS_14;
      endcase
    end
  endfunction

  // fit a 14-bit pattern word to the selected resolution, msb aligned
  function [15:0] res_fit;
    input [13:0] v;
    input [1:0]  code;
    begin
      case (code)
        `OTP_WL_16: res_fit = {v, 2'b00};
        `OTP_WL_12: res_fit = {4'h0, v[13:2]};
        default:    res_fit = {2'b00, v};
      endcase
    end
  endfunction

  // configuration writes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q     <= `OTP_MODE_OFF;
      user1_lo_q <= 8'h00;
      user1_hi_q <= 8'h00;
      user2_lo_q <= 8'h00;
      user2_hi_q <= 8'h00;
      fmt_q      <= `OTP_FMT_RESET;
      stuff_q    <= 8'h00;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `OTP_REG_TEST_MODE:  mode_q     <= cfg_wdata[3:0];
        `OTP_REG_USER1_LO:   user1_lo_q <= cfg_wdata;
        `OTP_REG_USER1_HI:   user1_hi_q <= cfg_wdata;
        `OTP_REG_USER2_LO:   user2_lo_q <= cfg_wdata;
        `OTP_REG_USER2_HI:   user2_hi_q <= cfg_wdata;
        `OTP_REG_OUT_FORMAT: fmt_q      <= cfg_wdata;
        `OTP_REG_STUFFING:   stuff_q    <= cfg_wdata;
        default: ;
      endcase
    end
  end

  // configuration reads, unmapped offsets read zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata_q <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `OTP_REG_TEST_MODE:  cfg_rdata_q <= {4'h0, mode_q};
        `OTP_REG_USER1_LO:   cfg_rdata_q <= user1_lo_q;
        `OTP_REG_USER1_HI:   cfg_rdata_q <= user1_hi_q;
        `OTP_REG_USER2_LO:   cfg_rdata_q <= user2_lo_q;
        `OTP_REG_USER2_HI:   cfg_rdata_q <= user2_hi_q;
        `OTP_REG_OUT_FORMAT: cfg_rdata_q <= fmt_q;
        `OTP_REG_STUFFING:   cfg_rdata_q <= stuff_q;
        `OTP_REG_STATUS:     cfg_rdata_q <= {zero_word_q, iq_q, tog_q, pn_on_q, act_mode_q};
        default:             cfg_rdata_q <= 8'h00;
      endcase
    end
  end

  // three-stage sampling of the link bit clock, change taken once stages two and three agree
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_sync_q   <= 3'b000;
      bclk_stable_q <= 1'b0;
    end else begin
      bclk_sync_q <= {bclk_sync_q[1:0], bit_clk};
      if (bclk_sync_q[1] == bclk_sync_q[2]) begin
        bclk_stable_q <= bclk_sync_q[2];
      end
    end
  end

  assign bit_edge = (bclk_sync_q[1] == bclk_sync_q[2]) && bclk_sync_q[2] && !bclk_stable_q;

  assign wl_bits   = wl_of(fmt_q[`OTP_FMT_WL_MSB:`OTP_FMT_WL_LSB]);
  assign lsb_first = fmt_q[`OTP_FMT_LSB_FIRST];
  assign boundary  = bit_edge && (bit_cnt_q == 5'h00);
  assign stuffing  = (stuff_left_q != 4'h0);
  assign new_pn    = (mode_q == `OTP_MODE_PN_LONG) || (mode_q == `OTP_MODE_PN_SHORT);
  assign pn_restart = boundary && !stuffing && new_pn && (mode_q != act_mode_q);

  // word chosen at the boundary from the mode now in force
  reg [15:0] word_r;
  always @* begin
    word_r = 16'h0000;
    if (!stuffing) begin
      case (mode_q)
        `OTP_MODE_OFF:     word_r = sample_data;
        `OTP_MODE_MID:     word_r = res_fit(`OTP_WORD_MID, fmt_q[1:0]);
        `OTP_MODE_POS_FS:  word_r = res_fit(`OTP_WORD_POS_FS, fmt_q[1:0]);
        `OTP_MODE_NEG_FS:  word_r = res_fit(`OTP_WORD_NEG_FS, fmt_q[1:0]);
        `OTP_MODE_CHECKER: word_r = {2'b00, tog_sel ? `OTP_WORD_CHECK_B : `OTP_WORD_CHECK_A};
        `OTP_MODE_TOGGLE:  word_r = {2'b00, tog_sel ? `OTP_WORD_ZEROS : `OTP_WORD_ONES};
        `OTP_MODE_USER:    word_r = tog_sel ? {user2_hi_q, user2_lo_q} : {user1_hi_q, user1_lo_q};
        default:           word_r = 16'h0000;
      endcase
    end
  end
  assign word = word_r;

  // msb first words sit at the top of the shifter, lsb first words at the bottom
  assign word_al = lsb_first ? word : (word << (5'h10 - wl_bits));

  // pseudorandom sources, stepped once per bit sent while active
  assign pn_step = bit_edge && (boundary ? (!stuffing && new_pn) : pn_on_q);
  assign pn_bit  = boundary ? (mode_q == `OTP_MODE_PN_LONG ? pnl_bit : pns_bit)
                            : (act_mode_q == `OTP_MODE_PN_LONG ? pnl_bit : pns_bit);

  otp_prbs #(
    .LEN    (`OTP_PNS_LEN),
    .TAP    (`OTP_PNS_TAP),
    .SEED   (`OTP_PNS_SEED),
    .INVERT (0)
  ) u_pn_short (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .load    (pn_restart && (mode_q == `OTP_MODE_PN_SHORT)),
    .step    (pn_step && (boundary ? mode_q : act_mode_q) == `OTP_MODE_PN_SHORT),
    .bit_out (pns_bit)
  );

  otp_prbs #(
    .LEN    (`OTP_PNL_LEN),
    .TAP    (`OTP_PNL_TAP),
    .SEED   (`OTP_PNL_SEED),
    .INVERT (1)
  ) u_pn_long (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .load    (pn_restart && (mode_q == `OTP_MODE_PN_LONG)),
    .step    (pn_step && (boundary ? mode_q : act_mode_q) == `OTP_MODE_PN_LONG),
    .bit_out (pnl_bit)
  );

  // serializer: load a word at the boundary, then one bit per link clock edge
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_mode_q    <= `OTP_MODE_OFF;
      bit_cnt_q     <= 5'h00;
      shreg_q       <= 16'h0000;
      tog_q         <= 1'b0;
      iq_q          <= 1'b0;
      stuff_left_q  <= 4'h0;
      pn_on_q       <= 1'b0;
      zero_word_q   <= 1'b0;
      ser_data_q    <= 1'b0;
      word_start_q  <= 1'b0;
      sample_take_q <= 1'b0;
    end else begin
      sample_take_q <= 1'b0;
      if (boundary) begin
        word_start_q <= 1'b1;
        bit_cnt_q    <= wl_bits - 5'h01;
        zero_word_q  <= stuffing;
        if (stuffing) begin
          stuff_left_q <= stuff_left_q - 4'h1;
          pn_on_q      <= 1'b0;
          ser_data_q   <= 1'b0;
          shreg_q      <= 16'h0000;
        end else begin
          act_mode_q <= mode_q;
          pn_on_q    <= new_pn;
          tog_q      <= ~tog_sel;
          if (mode_q == `OTP_MODE_OFF) begin
            sample_take_q <= 1'b1;
          end
          // a complex pair counts as one sample before stuffing
          if (stuff_q[`OTP_STF_COMPLEX] && !iq_q) begin
            iq_q <= 1'b1;
          end else begin
            iq_q         <= 1'b0;
            stuff_left_q <= stuff_q[`OTP_STF_CNT_MSB:0];
          end
          if (new_pn) begin
            ser_data_q <= pn_bit;
          end else begin
            ser_data_q <= lsb_first ? word_al[0] : word_al[15];
          end
          shreg_q <= lsb_first ? (word_al >> 1) : (word_al << 1);
        end
      end else if (bit_edge) begin
        word_start_q <= 1'b0;
        bit_cnt_q    <= bit_cnt_q - 5'h01;
        if (pn_on_q) begin
          ser_data_q <= pn_bit;
        end else begin
          ser_data_q <= lsb_first ? shreg_q[0] : shreg_q[15];
        end
        shreg_q <= lsb_first ? (shreg_q >> 1) : (shreg_q << 1);
      end
    end
  end

endmodule // otp_pattern_gen

`default_nettype wire

/* design/otp_defs.vh */
// constants for the output test pattern generator: register map, field codes, pattern seeds
// assumes plain verilog-2005 tools; included by bare name from the pattern generator only
`ifndef OTP_DEFS_VH
`define OTP_DEFS_VH

// register offsets on the configuration port
`define OTP_REG_TEST_MODE    12'h00D
`define OTP_REG_USER1_LO     12'h019
`define OTP_REG_USER1_HI     12'h01A
`define OTP_REG_USER2_LO     12'h01B
`define OTP_REG_USER2_HI     12'h01C
`define OTP_REG_OUT_FORMAT   12'h021
`define OTP_REG_STUFFING     12'h022
`define OTP_REG_STATUS       12'h023

// output format register fields
`define OTP_FMT_WL_LSB       0
`define OTP_FMT_WL_MSB       1
`define OTP_FMT_LSB_FIRST    2
`define OTP_FMT_RESET        8'h00

// stuffing register fields
`define OTP_STF_CNT_MSB      3
`define OTP_STF_COMPLEX      4

// word length codes and widths
`define OTP_WL_14            2'b00
`define OTP_WL_16            2'b01
`define OTP_WL_12            2'b10
`define OTP_BITS_12          5'h0C
`define OTP_BITS_14          5'h0E
`define OTP_BITS_16          5'h10

// test mode codes
`define OTP_MODE_OFF         4'h0
`define OTP_MODE_MID         4'h1
`define OTP_MODE_POS_FS      4'h2
`define OTP_MODE_NEG_FS      4'h3
`define OTP_MODE_CHECKER     4'h4
`define OTP_MODE_PN_LONG     4'h5
`define OTP_MODE_PN_SHORT    4'h6
`define OTP_MODE_TOGGLE      4'h7
`define OTP_MODE_USER        4'h8

// fixed 14-bit pattern words
`define OTP_WORD_MID         14'h2000
`define OTP_WORD_POS_FS      14'h3FFF
`define OTP_WORD_NEG_FS      14'h0000
`define OTP_WORD_CHECK_A     14'h2AAA
`define OTP_WORD_CHECK_B     14'h1555
`define OTP_WORD_ONES        14'h3FFF
`define OTP_WORD_ZEROS       14'h0000

// pseudorandom generators: length, second tap, seed
`define OTP_PNS_LEN          9
`define OTP_PNS_TAP          5
`define OTP_PNS_SEED         9'h092
`define OTP_PNL_LEN          23
`define OTP_PNL_TAP          18
// shift register image of the 0x3AFF start in the oldest-stage-out, xnor form used here
`define OTP_PNL_SEED         23'h0051FF

`endif

/* design/otp_prbs.v */
// one pseudorandom bit generator of the form x^len + x^tap + 1
// assumes step is a one-cycle strobe per output bit and load restarts from the seed
`timescale 1ns/1ps
`default_nettype none

module otp_prbs #(
  parameter             LEN    = 9,
  parameter             TAP    = 5,
  parameter [LEN-1:0]   SEED   = 9'h092,
  parameter             INVERT = 0
) (
  // clock and reset
  input  wire           sys_clk,
  input  wire           rst_b,
  // control
  input  wire           load,
  input  wire           step,
  // serial bit of the current step
  output wire           bit_out
);

  reg  [LEN-1:0] state_q;
  wire [LEN-1:0] cur;
  wire           fb;

  // a load presents the seed at once so the first bit comes from it
  assign cur     = load ? SEED : state_q;
  // an inverted stream is the same as an xnor generator with its oldest stage inverted
  assign fb      = cur[LEN-1] ^ cur[TAP-1] ^ (INVERT != 0);
  // the oldest stage leaves first, so the seed bits open the stream
  assign bit_out = cur[LEN-1] ^ (INVERT != 0);

  // advance one stage per output bit
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEED;
    end else if (step) begin
      state_q <= {cur[LEN-2:0], fb};
    end else if (load) begin
      state_q <= SEED;
    end
  end

endmodule // otp_prbs

`default_nettype wire

/* sim/otp_pattern_gen_asserts.sv */
// port checker for the output pattern generator
// assumes one sys_clk domain and bind onto otp_pattern_gen
`timescale 1ns/1ps
`default_nettype none
module otp_pattern_gen_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // configuration port
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata_q,
  // samples and link
  input wire logic        sample_take_q,
  input wire logic        bit_clk,
  input wire logic        ser_data_q,
  input wire logic        word_start_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // user byte write, then a read of the same place
  sequence s_user_wr;
    cfg_wr && cfg_addr >= 12'h019 && cfg_addr <= 12'h01C;
  endsequence
  sequence s_same_rd;
    cfg_rd && !cfg_wr && cfg_addr == $past(cfg_addr);
  endsequence
  a_user_readback: assert property (s_user_wr ##1 s_same_rd |=> cfg_rdata_q == $past(cfg_wdata, 2))
    else $error("user byte read back differs");
  a_unmapped_zero: assert property (cfg_rd && cfg_addr == 12'h0FF |=> cfg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!cfg_rd |=> $stable(cfg_rdata_q))
    else $error("read data moved without a read");
  a_take_in_word: assert property (sample_take_q |-> word_start_q)
    else $error("sample taken outside a word start");
  a_take_pulse: assert property (sample_take_q |=> !sample_take_q)
    else $error("sample take longer than one cycle");
  a_bit_on_edge: assert property ($changed(ser_data_q) |-> bit_clk)
    else $error("serial bit changed away from a bit clock rise");
  a_start_on_edge: assert property ($rose(word_start_q) |-> bit_clk)
    else $error("word start away from a bit clock rise");
  a_start_stands: assert property ($rose(word_start_q) |=> word_start_q [*8])
    else $error("word start shorter than a bit");
  a_start_spaced: assert property ($fell(word_start_q) |-> !word_start_q [*8])
    else $error("word start back too soon");
endmodule // otp_pattern_gen_asserts
bind otp_pattern_gen otp_pattern_gen_asserts otp_pattern_gen_asserts_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
  .sample_take_q(sample_take_q), .bit_clk(bit_clk), .ser_data_q(ser_data_q), .word_start_q(word_start_q));
`default_nettype wire

/* sim/otp_rx_model.sv */
// receiver model: makes the bit clock and captures serial words
// assumes bits settle well before the falling bit clock edge
`timescale 1ns/1ps
`default_nettype none
module otp_rx_model (
  // link
  output var logic        bit_clk,
  input  wire logic       ser_data_q,
  input  wire logic       word_start_q,
  // captured words
  output var logic [15:0] rx_word,
  output var logic [31:0] rx_cnt
);
  logic [15:0] sh_q = 16'h0000;
  // free running bit clock, phase unrelated to sys_clk
  initial begin
    bit_clk = 1'b0;
    rx_word = 16'h0000;
    rx_cnt = 32'h0;
    #3.3;
    forever #62.5 bit_clk = ~bit_clk;
  end
  // mid bit sampling, msb first; a word start closes the previous word
  always @(negedge bit_clk) begin
    if (word_start_q) begin
      rx_word <= sh_q;
      rx_cnt <= rx_cnt + 32'h1;
      sh_q <= {15'h0000, ser_data_q};
    end else begin
      sh_q <= {sh_q[14:0], ser_data_q};
    end
  end
endmodule // otp_rx_model
`default_nettype wire

/* sim/otp_pattern_gen_tb.sv */
// self-checking bench for the output pattern generator
// assumes the receiver model makes the bit clock and captures words
`timescale 1ns/1ps
`default_nettype none
module otp_pattern_gen_tb;
  logic        sys_clk, rst_b, cfg_wr, cfg_rd, sample_take_q, bit_clk, ser_data_q, word_start_q;
  logic [11:0] cfg_addr;
  logic [7:0]  cfg_wdata, cfg_rdata_q, b;
  logic [15:0] sample_data, w0, w1, w2, rx_word;
  logic [31:0] rx_cnt;
  int          failures = 0, checks = 0, i, k;
  logic [7:0]  ub [4] = '{8'h5A, 8'hC3, 8'hF0, 8'h0F};
  logic [7:0]  tf [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 8'h02, 8'h05};
  logic [3:0]  tm [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h1, 4'h1, 4'h4, 4'h8};
  logic [15:0] t1 [10] = '{16'h8000, 16'hFFFC, 16'h0000, 16'h2AAA, 16'h3FFF, 16'hC35A, 16'h0800, 16'h2000,
                           16'h0AAA, 16'h5AC3};
  logic [15:0] t2 [10] = '{16'h8000, 16'hFFFC, 16'h0000, 16'h1555, 16'h0000, 16'h0FF0, 16'h0800, 16'h2000,
                           16'h0555, 16'h0FF0};
  logic [15:0] pe [9] = '{16'h496F, 16'hC9A9, 16'h980C, 16'hFF5C, 16'h0029, 16'hB80A, 16'h0496, 16'h0FC9,
                          16'h0A99};

  otp_pattern_gen otp_pattern_gen_i (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q), .sample_data(sample_data),
    .sample_take_q(sample_take_q), .bit_clk(bit_clk), .ser_data_q(ser_data_q), .word_start_q(word_start_q));
  otp_rx_model otp_rx_model_i (.bit_clk(bit_clk), .ser_data_q(ser_data_q), .word_start_q(word_start_q),
    .rx_word(rx_word), .rx_cnt(rx_cnt));

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes, entered just after an edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge sys_clk);
    #1 cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge sys_clk);
    #1 cfg_rd = 1'b0;
    @(posedge sys_clk);
    #1 d = cfg_rdata_q;
  endtask
  // next captured word, bounded wait
  task automatic nxt(output logic [15:0] w);
    logic [31:0] c0;
    int          n;
    c0 = rx_cnt;
    n = 0;
    while (rx_cnt == c0 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 600) begin
      failures++;
      end_of_test();
    end
    #1 w = rx_word;
  endtask
  task automatic skip;
    nxt(w2);
    nxt(w2);
  endtask

  initial begin
    rst_b = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'h000;
    cfg_wdata = 8'h00;
    sample_data = 16'h1234;
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(12'h019 + 12'(i), b);
      chk("user reset", 16'h0000, {8'h00, b});
      wr(12'h019 + 12'(i), ub[i]);
      rd(12'h019 + 12'(i), b);
      chk("user byte", {8'h00, ub[i]}, {8'h00, b});
    end
    rd(12'h0FF, b);
    chk("unmapped", 16'h0000, {8'h00, b});
    $display("test registers done");
    wr(12'h021, 8'h01);
    skip();
    nxt(w0);
    chk("mode off", 16'h1234, w0);
    $display("test mode off done");
    for (k = 0; k < 10; k++) begin
      wr(12'h021, tf[k]);
      wr(12'h00D, {4'h0, tm[k]});
      skip();
      nxt(w0);
      nxt(w1);
      nxt(w2);
      if (w0 !== t1[k]) begin
        w0 = w1;
        w1 = w2;
      end
      chk("pattern one", t1[k], w0);
      chk("pattern two", t2[k], w1);
    end
    $display("test fixed and user patterns done");
    for (k = 0; k < 3; k++) begin
      wr(12'h00D, 8'h00);
      wr(12'h021, k == 2 ? 8'h02 : 8'h01);
      skip();
      nxt(w0);
      wr(12'h00D, k == 1 ? 8'h05 : 8'h06);
      nxt(w0);
      for (i = 0; i < 3; i++) begin
        nxt(w0);
        chk("pn word", pe[3*k+i], w0);
      end
    end
    $display("test pseudorandom done");
    wr(12'h021, 8'h01);
    wr(12'h00D, 8'h02);
    wr(12'h022, 8'h01);
    skip();
    nxt(w0);
    nxt(w1);
    chk("stuffed pair", 16'hFFFC, w0 | w1);
    chk("stuffed zero", 16'h0000, w0 & w1);
    $display("test zero stuffing done");
    end_of_test();
  end
endmodule // otp_pattern_gen_tb
`default_nettype wire
